// ==== src/pfm_monitor.sv ====
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "pfm_cfg.svh"

// What this block does
// - In run mode, flag sets when process value drops below the lower limit.
// - Set flag holds until process value rises above the upper limit.
// - Leaving run mode clears the flag whatever the process value.
// - Flag is an indication only; it never trips the drive or faults.
// - Output 11, output 12 or relay with selector code 07 follows the flag.
// - Feedback selector 00 takes the actual value from the current input.
// - Feedback selector 01 takes the actual value from the voltage input.
// - Without inversion, raise frequency below reference, lower it above.
// - Inversion setting 01 reverses the error sign.
// - Input window maps linearly onto feedback percentages; swapping them inverts.
// - With a scale factor, reference is in units; factor times 100 is 100 percent.
// - The reference is held as a 10-bit quantity.
// - Fixed reference 1 may replace the keypad reference as setpoint.
// - Scaling, inversion and flag run only while PID enable equals 01.
module pfm_monitor (
    // Clock, reset, enable
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    // Register port
    input  wire pfm_pkg::pfm_bus_req_t bus,
    output logic [31:0]             rdata,
    // Process side
    input  wire pfm_pkg::pfm_val_t  current_analog_input,
    input  wire pfm_pkg::pfm_val_t  voltage_analog_input,
    input  wire logic               run_mode,
    input  wire logic               sample_tick,
    // Results
    output logic                    feedback_check_flag,
    output pfm_pkg::pfm_dout_t      dout,
    output pfm_pkg::pfm_val_t       process_value,
    output pfm_pkg::pfm_val_t       setpoint,
    output pfm_pkg::pfm_err_t       control_error,
    output logic                    freq_raise,
    output logic                    freq_lower,
    output logic                    irq
);
    import pfm_pkg::*;

    pfm_state_t s;
    pfm_state_t next_s;
    pfm_val_t   fb_in;
    pfm_val_t   pv_raw;
    pfm_dout_t  dout_n;
    logic       pid_on;
    logic [16:0] ref_units;
    logic [16:0] sp_wide;
    logic [1:0]  ev;

    assign pid_on = (s.ctrl.pid_en == `PFM_PID_ON);

    // Other selector codes fall back to the current input
    assign fb_in = (s.ctrl.fb_sel == `PFM_FB_VOLTAGE) ? voltage_analog_input
                                                      : current_analog_input;

    pfm_scaler u_scaler (
        .x   (fb_in),
        .thr (s.thr),
        .pct (s.pct),
        .pv  (pv_raw)
    );

    pfm_outsel u_outsel (
        .sel  (next_s.sel),
        .flag (next_s.flag),
        .dout (dout_n)
    );

    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0000_0000;
        ev = 2'b00;

        // Reference source and unit conversion
        ref_units = {7'h00, (s.ctrl.ref_src == `PFM_SRC_FIXED) ? s.fixref
                                                               : s.keyref};
        if (s.scale != `PFM_RST_ZERO) begin
            // Factor is held in tenths, so factor*100 units equals 1000 steps
            sp_wide = (ref_units * `PFM_PCT_SCALE) / {7'h00, s.scale};
        end else begin
            sp_wide = ref_units;
        end
        if (sp_wide > {7'h00, `PFM_RST_FULL}) begin
            sp_wide = {7'h00, `PFM_RST_FULL};
        end

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                `PFM_A_CTRL: begin
                    next_s.ctrl.pid_en  = bus.wdata[`PFM_F_PIDEN];
                    next_s.ctrl.fb_sel  = bus.wdata[`PFM_F_FBSEL];
                    next_s.ctrl.inv     = bus.wdata[`PFM_F_INV];
                    next_s.ctrl.ref_src = bus.wdata[`PFM_F_REFSRC];
                end
                `PFM_A_OUTSEL: begin
                    next_s.sel[0] = bus.wdata[`PFM_F_SEL11];
                    next_s.sel[1] = bus.wdata[`PFM_F_SEL12];
                    next_s.sel[2] = bus.wdata[`PFM_F_SELK];
                end
                `PFM_A_LIMITS: next_s.lim = '{bus.wdata[`PFM_F_LO], bus.wdata[`PFM_F_HI]};
                `PFM_A_THRESH: next_s.thr = '{bus.wdata[`PFM_F_LO], bus.wdata[`PFM_F_HI]};
                `PFM_A_PCT:    next_s.pct = '{bus.wdata[`PFM_F_LO], bus.wdata[`PFM_F_HI]};
                `PFM_A_SCALE:  next_s.scale  = bus.wdata[`PFM_F_VAL];
                `PFM_A_KEYREF: next_s.keyref = bus.wdata[`PFM_F_VAL];
                `PFM_A_FIXREF: next_s.fixref = bus.wdata[`PFM_F_VAL];
                `PFM_A_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~bus.wdata[`PFM_F_IRQ];
                `PFM_A_IRQ_MASK: next_s.irq_mask = bus.wdata[`PFM_F_IRQ];
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle
        if (bus.rd) begin
            case (bus.addr)
                `PFM_A_CTRL:   next_s.rdata[7:0] = {s.ctrl.ref_src, s.ctrl.inv,
                                                    s.ctrl.fb_sel, s.ctrl.pid_en};
                `PFM_A_OUTSEL: next_s.rdata[23:0] = {s.sel[2], s.sel[1], s.sel[0]};
                `PFM_A_LIMITS: next_s.rdata = {6'h00, s.lim.upper, 6'h00, s.lim.lower};
                `PFM_A_THRESH: next_s.rdata = {6'h00, s.thr.upper, 6'h00, s.thr.lower};
                `PFM_A_PCT:    next_s.rdata = {6'h00, s.pct.upper, 6'h00, s.pct.lower};
                `PFM_A_SCALE:  next_s.rdata[9:0] = s.scale;
                `PFM_A_KEYREF: next_s.rdata[9:0] = s.keyref;
                `PFM_A_FIXREF: next_s.rdata[9:0] = s.fixref;
                `PFM_A_STATUS: begin
                    next_s.rdata[`PFM_F_ST_FLAG] = s.flag;
                    next_s.rdata[`PFM_F_ST_RUN]  = run_mode;
                    next_s.rdata[`PFM_F_ST_PV]   = s.pv;
                end
                `PFM_A_IRQ_STAT: next_s.rdata[1:0] = s.irq_stat;
                `PFM_A_IRQ_MASK: next_s.rdata[1:0] = s.irq_mask;
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // Loop arithmetic, refreshed once per control sample
        if (!pid_on) begin
            next_s.raise = 1'b0;
            next_s.lower = 1'b0;
        end else if (sample_tick) begin
            next_s.pv = pv_raw;
            next_s.sp = sp_wide[9:0];
            if (s.ctrl.inv == `PFM_INV_ON) begin
                next_s.err = pfm_err_t'({1'b0, pv_raw}) - pfm_err_t'({1'b0, sp_wide[9:0]});
            end else begin
                next_s.err = pfm_err_t'({1'b0, sp_wide[9:0]}) - pfm_err_t'({1'b0, pv_raw});
            end
            next_s.raise = (next_s.err > 11'sd0);
            next_s.lower = (next_s.err < 11'sd0);
        end

        // Hysteresis monitor; it only drives outputs, no trip path exists
        if (!run_mode || !pid_on) begin
            next_s.flag = 1'b0;
        end else if (sample_tick) begin
            if (pv_raw < s.lim.lower) begin
                next_s.flag = 1'b1;
            end else if (pv_raw > s.lim.upper) begin
                next_s.flag = 1'b0;
            end
        end

        next_s.dout = dout_n;

        // Sticky events; a new event beats a clear in the same cycle
        ev[`PFM_IRQ_RAISED]  = next_s.flag & ~s.flag;
        ev[`PFM_IRQ_DROPPED] = ~next_s.flag & s.flag;
        next_s.irq_stat = next_s.irq_stat | ev;
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
    end

    // Reset opens the input window to full span so feedback passes unscaled
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.thr.upper <= `PFM_RST_FULL;
            s.pct.upper <= `PFM_RST_FULL;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign rdata               = s.rdata;
    assign feedback_check_flag = s.flag;
    assign dout                = s.dout;
    assign process_value       = s.pv;
    assign setpoint            = s.sp;
    assign control_error       = s.err;
    assign freq_raise          = s.raise;
    assign freq_lower          = s.lower;
    assign irq                 = s.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence low_sample;
        ce && sample_tick && run_mode && pid_on && (pv_raw < s.lim.lower);
    endsequence

    sequence high_sample;
        ce && sample_tick && run_mode && pid_on && (pv_raw > s.lim.upper);
    endsequence

    low_sets_flag_a: assert property (low_sample |=> feedback_check_flag)
        else $error("flag not set below lower limit");

    hyst_hold_a: assert property (
        (ce && feedback_check_flag && run_mode && pid_on
         && !(sample_tick && pv_raw > s.lim.upper)) |=> feedback_check_flag)
        else $error("flag dropped inside hysteresis band");

    high_clears_a: assert property (high_sample ##1 (ce && run_mode && !sample_tick)
        |=> !feedback_check_flag)
        else $error("flag stayed set above upper limit");

    stop_clears_a: assert property ((ce && !run_mode) |=> !feedback_check_flag)
        else $error("flag not cleared on stop");

    out_follow_a: assert property (
        (s.sel[0] == `PFM_OUT_FBV) |-> (dout[0] == feedback_check_flag))
        else $error("output 11 does not follow flag");

    out12_follow_a: assert property (
        (s.sel[1] == `PFM_OUT_FBV) |-> (dout[1] == feedback_check_flag))
        else $error("output 12 does not follow flag");

    relay_follow_a: assert property (
        (s.sel[2] == `PFM_OUT_FBV) |-> (dout[2] == feedback_check_flag))
        else $error("relay does not follow flag");

    current_low_a: assert property (
        (ce && sample_tick && pid_on && s.ctrl.fb_sel == `PFM_FB_CURRENT
         && current_analog_input <= s.thr.lower) |=> (process_value == $past(s.pct.lower)))
        else $error("current input not used as feedback");

    volt_high_a: assert property (
        (ce && sample_tick && pid_on && s.ctrl.fb_sel == `PFM_FB_VOLTAGE
         && voltage_analog_input >= s.thr.upper && s.thr.upper > s.thr.lower)
        |=> (process_value == $past(s.pct.upper)))
        else $error("voltage input not used as feedback");

    raise_dir_a: assert property (
        (ce && pid_on && sample_tick && s.ctrl.inv != `PFM_INV_ON)
        |=> (freq_raise == (process_value < setpoint)))
        else $error("raise without feedback below reference");

    inv_dir_a: assert property (
        (ce && pid_on && sample_tick && s.ctrl.inv == `PFM_INV_ON)
        |=> (freq_raise == (process_value > setpoint)))
        else $error("inverted raise with feedback not above reference");

    err_calc_a: assert property (
        (ce && pid_on && sample_tick && s.ctrl.inv != `PFM_INV_ON)
        |=> (control_error == pfm_err_t'({1'b0, setpoint}) - pfm_err_t'({1'b0, process_value})))
        else $error("control error is not reference minus feedback");

    err_inv_a: assert property (
        (ce && pid_on && sample_tick && s.ctrl.inv == `PFM_INV_ON)
        |=> (control_error == pfm_err_t'({1'b0, process_value}) - pfm_err_t'({1'b0, setpoint})))
        else $error("inverted control error is not feedback minus reference");

    pid_off_a: assert property ((ce && !pid_on)
        |=> (!feedback_check_flag && !freq_raise && !freq_lower))
        else $error("monitor active while loop disabled");

    sample_only_a: assert property ((ce && !sample_tick && run_mode && pid_on)
        |=> $stable(feedback_check_flag))
        else $error("flag changed between samples");

    // Held loop values let a re-enabled loop resume from its last sample
    pv_hold_a: assert property ((ce && !pid_on)
        |=> ($stable(process_value) && $stable(setpoint) && $stable(control_error)))
        else $error("loop values moved while loop disabled");

    sp_clamp_a: assert property (setpoint <= `PFM_RST_FULL)
        else $error("setpoint above full scale");

    fixref_sp_a: assert property (
        (ce && pid_on && sample_tick && s.scale == `PFM_RST_ZERO
         && s.ctrl.ref_src == `PFM_SRC_FIXED && s.fixref <= `PFM_RST_FULL)
        |=> (setpoint == $past(s.fixref)))
        else $error("fixed reference not used as setpoint");

    // Read port answers once and returns to zero
    status_read_a: assert property ((ce && bus.rd && bus.addr == `PFM_A_STATUS)
        |=> (rdata[`PFM_F_ST_FLAG] == $past(feedback_check_flag)))
        else $error("status read does not show the flag");

    rdata_idle_a: assert property ((ce && !bus.rd) |=> (rdata == 32'h0000_0000))
        else $error("read data outside the answer cycle");

    // Interrupt status must catch both edges of the flag
    irq_rise_a: assert property ($rose(feedback_check_flag) |-> s.irq_stat[`PFM_IRQ_RAISED])
        else $error("flag rise not recorded");

    irq_drop_a: assert property ($fell(feedback_check_flag) |-> s.irq_stat[`PFM_IRQ_DROPPED])
        else $error("flag fall not recorded");
endmodule

// ==== src/pfm_cfg.svh ====
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH

// Register indices on the plain register port
`define PFM_A_CTRL      4'h0
`define PFM_A_OUTSEL    4'h1
`define PFM_A_LIMITS    4'h2
`define PFM_A_THRESH    4'h3
`define PFM_A_PCT       4'h4
`define PFM_A_SCALE     4'h5
`define PFM_A_KEYREF    4'h6
`define PFM_A_FIXREF    4'h7
`define PFM_A_STATUS    4'h8
`define PFM_A_IRQ_STAT  4'h9
`define PFM_A_IRQ_MASK  4'hA

// Field positions
`define PFM_F_PIDEN     1:0
`define PFM_F_FBSEL     3:2
`define PFM_F_INV       5:4
`define PFM_F_REFSRC    7:6
`define PFM_F_SEL11     7:0
`define PFM_F_SEL12     15:8
`define PFM_F_SELK      23:16
`define PFM_F_LO        9:0
`define PFM_F_HI        25:16
`define PFM_F_VAL       9:0
`define PFM_F_IRQ       1:0
`define PFM_F_ST_FLAG   0
`define PFM_F_ST_RUN    1
`define PFM_F_ST_PV     25:16

// Setting codes
`define PFM_PID_ON      2'h1
`define PFM_FB_CURRENT  2'h0
`define PFM_FB_VOLTAGE  2'h1
`define PFM_INV_ON      2'h1
`define PFM_SRC_FIXED   2'h1
`define PFM_OUT_FBV     8'h07

// Reset values (values in 0.1 % steps, 1000 = 100 %)
`define PFM_RST_FULL    10'h3E8
`define PFM_RST_ZERO    10'h000
`define PFM_PCT_SCALE   17'h0_0064

// Interrupt status bits
`define PFM_IRQ_RAISED  0
`define PFM_IRQ_DROPPED 1

`endif

// ==== src/pfm_pkg.sv ====
package pfm_pkg;

    typedef logic [9:0]        pfm_val_t;
    typedef logic signed [10:0] pfm_err_t;
    typedef logic [7:0]        pfm_sel_t;

    typedef struct packed {
        logic [1:0] pid_en;
        logic [1:0] fb_sel;
        logic [1:0] inv;
        logic [1:0] ref_src;
    } pfm_ctrl_t;

    typedef struct packed {
        pfm_val_t lower;
        pfm_val_t upper;
    } pfm_span_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pfm_bus_req_t;

    // Index 0 = digital output 11, 1 = digital output 12, 2 = signalling relay
    typedef logic [2:0] pfm_dout_t;

    typedef struct packed {
        pfm_ctrl_t        ctrl;
        pfm_sel_t [2:0]   sel;
        pfm_span_t        lim;
        pfm_span_t        thr;
        pfm_span_t        pct;
        pfm_val_t         scale;
        pfm_val_t         keyref;
        pfm_val_t         fixref;
        logic [1:0]       irq_stat;
        logic [1:0]       irq_mask;
        logic             irq;
        logic             flag;
        pfm_dout_t        dout;
        pfm_val_t         pv;
        pfm_val_t         sp;
        pfm_err_t         err;
        logic             raise;
        logic             lower;
        logic [31:0]      rdata;
    } pfm_state_t;

endpackage

// ==== src/pfm_scaler.sv ====
`timescale 1ns/100ps
module pfm_scaler (
    // Raw input and acceptance window
    input  wire pfm_pkg::pfm_val_t  x,
    input  wire pfm_pkg::pfm_span_t thr,
    // Feedback percentages at the window ends
    input  wire pfm_pkg::pfm_span_t pct,
    // Scaled feedback
    output logic [9:0]              pv
);
    import pfm_pkg::*;

    logic signed [22:0] num;
    logic signed [22:0] den;
    logic signed [22:0] res;

    // Straight line between the two window ends; swapped percentages give a falling line
    always_comb begin
        num = 23'(signed'({1'b0, x})) - 23'(signed'({1'b0, thr.lower}));
        num = num * (23'(signed'({1'b0, pct.upper})) - 23'(signed'({1'b0, pct.lower})));
        den = 23'(signed'({1'b0, thr.upper})) - 23'(signed'({1'b0, thr.lower}));
        res = 23'(signed'({1'b0, pct.lower}));
        if (x <= thr.lower || den <= 23'sd0) begin
            pv = pct.lower;
        end else if (x >= thr.upper) begin
            pv = pct.upper;
        end else begin
            res = res + num / den;
            pv = res[9:0];
        end
    end
endmodule

// ==== src/pfm_outsel.sv ====
`timescale 1ns/100ps
`include "pfm_cfg.svh"
module pfm_outsel (
    // Function selectors of the three switching outputs
    input  wire pfm_pkg::pfm_sel_t [2:0] sel,
    // Flag to route
    input  wire logic                    flag,
    // Output levels
    output pfm_pkg::pfm_dout_t           dout
);
    import pfm_pkg::*;

    // Other function codes belong to blocks outside this one and read low here
    for (genvar i = 0; i < 3; i++) begin : g_out
        assign dout[i] = (sel[i] == `PFM_OUT_FBV) ? flag : 1'b0;
    end
endmodule

// ==== sim/pfm_plant.sv ====
`timescale 1ns/100ps
module pfm_plant (
    // Clock
    input  wire logic              clk,
    // Levels asked of the sensor
    input  wire pfm_pkg::pfm_val_t level_current,
    input  wire pfm_pkg::pfm_val_t level_voltage,
    // Sensor lines
    output pfm_pkg::pfm_val_t      current_out,
    output pfm_pkg::pfm_val_t      voltage_out,
    // Starter of the second motor
    input  wire logic              start_cmd,
    output logic                   motor2_on
);
    import pfm_pkg::*;

    // Sensor has no lag, so the block sees every step at once
    assign current_out = level_current;
    assign voltage_out = level_voltage;

    always_ff @(posedge clk) begin
        motor2_on <= start_cmd;
    end
endmodule

// ==== sim/pid_feedback_window_monitor_test.sv ====
`timescale 1ns/100ps
`include "pfm_cfg.svh"
module pid_feedback_window_monitor_test;
    import pfm_pkg::*;

    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] ONE  = 32'h0000_0001;

    logic         clk, nrst, ce, run_mode, sample_tick;
    logic         flag, raise, lower, irq, m2, ef, r, t, k;
    pfm_bus_req_t bus;
    logic [31:0]  rdata, seed;
    pfm_val_t     lvl_c, lvl_v, cur, volt, pv, sp, v;
    pfm_dout_t    dout;
    pfm_err_t     err;
    int           failures, checks, i;

    pfm_plant plant (.clk(clk), .level_current(lvl_c), .level_voltage(lvl_v),
        .current_out(cur), .voltage_out(volt), .start_cmd(dout[2]), .motor2_on(m2));

    pfm_monitor dut (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus), .rdata(rdata),
        .current_analog_input(cur), .voltage_analog_input(volt), .run_mode(run_mode),
        .sample_tick(sample_tick), .feedback_check_flag(flag), .dout(dout),
        .process_value(pv), .setpoint(sp), .control_error(err), .freq_raise(raise),
        .freq_lower(lower), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand one cycle only, so they are taken just after that edge
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask

    task automatic smp(input pfm_val_t c, input pfm_val_t vv, input logic rn,
                       input logic tk = 1'b1, input logic en = 1'b1);
        @(posedge clk);
        lvl_c <= c;
        lvl_v <= vv;
        run_mode <= rn;
        sample_tick <= tk;
        ce <= en;
        @(posedge clk);
        sample_tick <= 1'b0;
        ce <= 1'b1;
        #1;
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        bus = '0;
        lvl_c = '0;
        lvl_v = '0;
        run_mode = 1'b0;
        sample_tick = 1'b0;
        failures = 0;
        checks = 0;
        seed = 32'h0000_0018;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(`PFM_A_CTRL, ZERO);
        rd(`PFM_A_THRESH, 32'h03E8_0000);
        rd(`PFM_A_PCT, 32'h03E8_0000);
        rd(4'hB, ZERO);
        chk("flag", ZERO, flag);
        done("reset");

        wr(`PFM_A_CTRL, ONE);
        wr(`PFM_A_OUTSEL, 32'h0007_0707);
        wr(`PFM_A_LIMITS, 32'h0258_00C8);
        wr(`PFM_A_IRQ_MASK, ONE);
        wr(`PFM_A_KEYREF, 32'h0000_01F4);
        smp(100, 900, 1);
        chk("flag", ONE, flag);
        chk("dout", 32'h0000_0007, dout);
        chk("err", 32'h0000_0190, {21'h0, err});
        chk("raise", ONE, raise);
        rd(`PFM_A_STATUS, 32'h0064_0003);
        chk("irq", ONE, irq);
        chk("motor2", ONE, m2);
        smp(600, 900, 1);
        chk("flag", ONE, flag);
        smp(601, 900, 1);
        chk("flag", ZERO, flag);
        rd(`PFM_A_IRQ_STAT, 32'h0000_0003);
        wr(`PFM_A_IRQ_STAT, ONE);
        rd(`PFM_A_IRQ_STAT, 32'h0000_0002);
        chk("irq", ZERO, irq);
        wr(`PFM_A_IRQ_MASK, 32'h0000_0003);
        rd(`PFM_A_IRQ_MASK, 32'h0000_0003);
        chk("irq", ONE, irq);
        wr(`PFM_A_IRQ_STAT, 32'h0000_0002);
        rd(`PFM_A_IRQ_STAT, ZERO);
        chk("irq", ZERO, irq);
        smp(100, 900, 1);
        smp(100, 900, 0);
        chk("flag", ZERO, flag);
        done("hysteresis");

        // Code 04 on the other two outputs must leave them low
        for (i = 0; i < 3; i++) begin
            wr(`PFM_A_OUTSEL, 32'h0004_0404 ^ (32'h0000_0003 << (8 * i)));
            smp(100, 900, 1);
            chk("dout", ONE << i, dout);
            smp(100, 900, 0);
        end
        done("outputs");

        wr(`PFM_A_CTRL, 32'h0000_0005);
        smp(900, 100, 1);
        chk("flag", ONE, flag);
        chk("pv", 32'h0000_0064, pv);
        smp(900, 1000, 1);
        chk("pv", 32'h0000_03E8, pv);
        chk("flag", ZERO, flag);
        wr(`PFM_A_CTRL, ONE);
        smp(900, 100, 1);
        chk("pv", 32'h0000_0384, pv);
        done("select");

        smp(700, 0, 1);
        chk("err", 32'h0000_0738, {21'h0, err});
        chk("lower", ONE, lower);
        wr(`PFM_A_CTRL, 32'h0000_0011);
        smp(700, 0, 1);
        chk("err", 32'h0000_00C8, {21'h0, err});
        chk("raise", ONE, raise);
        wr(`PFM_A_CTRL, 32'h0000_0041);
        rd(`PFM_A_CTRL, 32'h0000_0041);
        wr(`PFM_A_FIXREF, 32'h0000_02BC);
        smp(300, 0, 1);
        chk("sp", 32'h0000_02BC, sp);
        wr(`PFM_A_CTRL, ONE);
        wr(`PFM_A_SCALE, 32'h0000_0032);
        wr(`PFM_A_KEYREF, 32'h0000_0096);
        smp(300, 0, 1);
        chk("sp", 32'h0000_012C, sp);
        wr(`PFM_A_KEYREF, 32'hFFFF_FFFF);
        rd(`PFM_A_KEYREF, 32'h0000_03FF);
        smp(300, 0, 1);
        chk("sp", 32'h0000_03E8, sp);
        wr(`PFM_A_SCALE, ZERO);
        done("reference");

        wr(`PFM_A_THRESH, 32'h03E8_00C8);
        smp(400, 0, 1);
        chk("pv", 32'h0000_00FA, pv);
        smp(100, 0, 1);
        chk("pv", ZERO, pv);
        wr(`PFM_A_PCT, 32'h0000_03E8);
        smp(400, 0, 1);
        chk("pv", 32'h0000_02EE, pv);
        wr(`PFM_A_THRESH, 32'h03E8_0000);
        wr(`PFM_A_PCT, 32'h03E8_0000);
        done("scaling");

        smp(100, 0, 1);
        wr(`PFM_A_CTRL, ZERO);
        smp(500, 0, 1);
        chk("flag", ZERO, flag);
        chk("pv", 32'h0000_0064, pv);
        chk("raise", ZERO, raise);
        chk("lower", ZERO, lower);
        done("disabled");

        wr(`PFM_A_CTRL, ONE);
        wr(`PFM_A_KEYREF, 32'h0000_01F4);
        ef = 1'b0;
        for (i = 0; i < 300; i++) begin
            seed = xs(seed);
            v = seed[25:16] % 10'h320;
            k = seed[2:0] != 3'h0;
            r = seed[5:3] != 3'h0;
            t = seed[6];
            if (k && !r)
                ef = 1'b0;
            else if (k && t && v < 10'h0C8)
                ef = 1'b1;
            else if (k && t && v > 10'h258)
                ef = 1'b0;
            smp(v, ~v, r, t, k);
            chk("flag", {31'h0, ef}, flag);
            // The idle cycle after each sample runs with ce high, so stop clears
            if (!r)
                ef = 1'b0;
        end
        done("random");
        give_verdict();
    end
endmodule
